// file: core/csf_engine.sv
// CSI-2 forwarding engine: four video buffers into one transmit port
`timescale 1ns/1ps
`default_nettype none
module csf_engine #(
  parameter int DATA_W = 32,
  parameter logic TX_INDEX = 1'b0,
  parameter int SYNC_WIN_CYC = csf_pkg::SYNC_WIN_CYC
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic tx_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Video buffer heads
  input wire logic [3:0] buf_pkt_ready,
  input wire logic [4*DATA_W-1:0] buf_data,
  input wire logic [3:0] buf_eop,
  input wire logic [7:0] buf_kind,
  input wire logic [7:0] port_vc,
  output logic [3:0] buf_pop_q,
  // Status
  output logic sync_status_q,
  output logic sync_lost_q,
  // CSI-2 output on tx_clk
  output logic tx_hs_q,
  output logic tx_valid_q,
  output logic [DATA_W-1:0] tx_data_q,
  output logic tx_first_q,
  output logic tx_last_q,
  output logic [1:0] tx_vc_q
);
  localparam int WAIT_W = $clog2(SYNC_WIN_CYC + 1);
  localparam logic [WAIT_W-1:0] WAIT_MAX = WAIT_W'(SYNC_WIN_CYC - 1);

  // Lowest-offset set bit of mask, searched from start: {found, index}
  function automatic logic [2:0] pick_from(input logic [3:0] mask, input logic [1:0] start);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      idx = start + 2'(i);
      if (mask[idx])
        res = {1'b1, idx};
    end
    return res;
  endfunction : pick_from

  csf_link_if #(.DATA_W(DATA_W)) link ();

  logic [7:0] map_q;
  logic [7:0] mode_q;
  csf_pkg::csf_state_type state_q;
  logic [1:0] sel_q;
  logic [1:0] rr_ptr_q;
  logic synced_q;
  logic [3:0] done_q;
  csf_pkg::csf_kind_type round_kind_q;
  logic [WAIT_W-1:0] wait_q;
  logic first_q;
  logic req_q;
  logic busy_q;
  logic [DATA_W-1:0] word_q;
  logic wfirst_q;
  logic wlast_q;
  logic [1:0] wvc_q;
  logic [2:0] ack_s_q;
  logic ack_acc_q;

  logic [DATA_W-1:0] head_data [4];
  csf_pkg::csf_kind_type head_kind [4];
  logic [1:0] head_vc [4];
  logic [3:0] fs_mask;

  // Unpack per-port buffer heads
  for (genvar p = 0; p < 4; p++)
  begin : g_head
    assign head_data[p] = buf_data[p*DATA_W +: DATA_W];
    assign head_kind[p] = csf_pkg::csf_kind_type'(buf_kind[2*p +: 2]);
    assign head_vc[p] = port_vc[2*p +: 2];
    assign fs_mask[p] = (head_kind[p] == csf_pkg::KIND_FS);
  end

  // Configuration decode
  logic [3:0] en_w;
  logic rr_on;
  logic [1:0] sync_sel;
  logic sync_on;
  logic pop_any;
  logic [3:0] ready_w;
  // only buffers mapped to this transmitter
  assign en_w = ~(map_q[csf_pkg::MAP_LSB +: 4] ^ {4{TX_INDEX}}) & ~map_q[csf_pkg::DIS_LSB +: 4];
  assign rr_on = mode_q[csf_pkg::RR_BIT];
  assign sync_sel = mode_q[csf_pkg::SYNC_LSB +: 2];
  assign sync_on = !rr_on && (sync_sel != csf_pkg::SYNC_OFF);
  assign pop_any = |buf_pop_q;
  // whole packet present; head only valid once pop settled
  assign ready_w = buf_pkt_ready & en_w & {4{~pop_any}};

  // Scheduling candidates
  logic [2:0] rr_pick;
  logic [2:0] low_en;
  logic [2:0] cand;
  logic [2:0] bad;
  logic [1:0] cand_idx;
  logic cand_rdy;
  csf_pkg::csf_kind_type cand_kind;
  logic hunt_ok;
  logic mismatch;
  logic timeout;
  logic merge_drop;
  // next pending port at or after the pointer
  assign rr_pick = pick_from(ready_w, rr_ptr_q);
  // lowest enabled port not yet served this round
  assign low_en = pick_from(en_w, 2'h0);
  assign cand = pick_from(en_w & ~done_q, 2'h0);
  assign cand_idx = cand[1:0];
  assign cand_rdy = ready_w[cand_idx];
  assign cand_kind = head_kind[cand_idx];
  assign bad = pick_from(ready_w & ~fs_mask, 2'h0);
  // restart only when every enabled port holds a FrameStart
  assign hunt_ok = (|en_w) && (&(~en_w | (ready_w & fs_mask)));
  // each round must carry one packet class across all ports
  assign mismatch = (|done_q) && cand_rdy && (cand_kind != round_kind_q);
  // a port late beyond the window, mid-round or while others wait, counts as lost sync
  assign timeout = ((|done_q) || (|ready_w)) && !cand_rdy && (wait_q == WAIT_MAX);
  // Merged variants keep only the lowest port's FrameStart and FrameEnd
  assign merge_drop = (sync_sel != csf_pkg::SYNC_BASIC) && (cand_idx != low_en[1:0])
    && ((cand_kind == csf_pkg::KIND_FS) || (cand_kind == csf_pkg::KIND_FE));

  // Decisions taken in the idle state
  logic idle_go;
  logic start_rr;
  logic hunt;
  logic hunt_drop;
  logic sync_go;
  logic round_wrap;
  logic lose;
  logic take;
  logic waiting;
  logic start_send;
  logic start_drop;
  logic [1:0] start_idx;
  assign idle_go = (state_q == csf_pkg::ST_IDLE) && !pop_any;
  assign start_rr = idle_go && rr_on && rr_pick[2];
  assign hunt = idle_go && sync_on && !synced_q;
  // discard anything that is not a FrameStart while hunting
  assign hunt_drop = hunt && !hunt_ok && bad[2];
  assign sync_go = idle_go && sync_on && synced_q;
  assign round_wrap = sync_go && !cand[2];
  assign lose = sync_go && cand[2] && (mismatch || timeout);
  // one packet per port per round in ascending order
  assign take = sync_go && cand[2] && cand_rdy && !mismatch;
  assign waiting = sync_go && cand[2] && !cand_rdy && ((|done_q) || (|ready_w));
  assign start_send = start_rr || (take && !merge_drop);
  assign start_drop = hunt_drop || (take && merge_drop);
  assign start_idx = start_rr ? rr_pick[1:0] : (hunt_drop ? bad[1:0] : cand_idx);

  // Word movement
  logic send_word;
  logic drop_word;
  logic ack_evt;
  logic lost_clr;
  logic [1:0] out_vc;
  assign send_word = (state_q == csf_pkg::ST_SEND) && !busy_q && !pop_any;
  assign drop_word = (state_q == csf_pkg::ST_DROP) && !pop_any;
  assign ack_evt = (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] != ack_acc_q);
  assign lost_clr = reg_rd && (reg_addr == csf_pkg::ADDR_STATUS);
  // port's own channel, or the lowest enabled port's in merged sync variants; channel is what separates streams
  assign out_vc = (sync_on && sync_sel != csf_pkg::SYNC_BASIC) ? head_vc[low_en[1:0]] : head_vc[sel_q];

  // Read data selection
  logic [7:0] sts_w;
  logic [7:0] rd_mux;
  assign sts_w = (8'(synced_q) << csf_pkg::STS_SYNC_BIT) | (8'(sync_lost_q) << csf_pkg::STS_LOST_BIT);
  assign rd_mux = (reg_addr == csf_pkg::ADDR_PORT_MAP) ? map_q :
                  (reg_addr == csf_pkg::ADDR_MODE) ? mode_q :
                  (reg_addr == csf_pkg::ADDR_STATUS) ? sts_w : 8'h00;

  // Configuration registers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      map_q <= csf_pkg::PORT_MAP_RST;
      mode_q <= csf_pkg::MODE_RST;
    end
    else if (reg_wr && reg_addr == csf_pkg::ADDR_PORT_MAP)
      map_q <= reg_wdata;
    else if (reg_wr && reg_addr == csf_pkg::ADDR_MODE)
      mode_q <= reg_wdata;
  end

  // Register read data
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= rd_mux;
  end

  // synced status and sticky lost flag, set wins over read-clear
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      synced_q <= 1'b0;
      sync_lost_q <= 1'b0;
    end
    else
    begin
      sync_lost_q <= lose | (sync_lost_q & ~lost_clr);
      // no sync status outside synchronized forwarding
      if (!sync_on)
        synced_q <= 1'b0;
      else if (hunt && hunt_ok)
        synced_q <= 1'b1;
      else if (lose)
        synced_q <= 1'b0;
    end
  end
  assign sync_status_q = synced_q;

  // round bookkeeping and class of the round
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_q <= 4'h0;
      round_kind_q <= csf_pkg::KIND_LINE;
    end
    else if (!synced_q || round_wrap)
      done_q <= 4'h0;
    else if (take)
    begin
      done_q[cand_idx] <= 1'b1;
      if (done_q == 4'h0)
        round_kind_q <= cand_kind;
    end
  end

  // Wait for the next port of a round
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wait_q <= '0;
    else if (!waiting)
      wait_q <= '0;
    else if (wait_q != WAIT_MAX)
      wait_q <= wait_q + WAIT_W'(1);
  end

  // Forwarding state machine
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= csf_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        csf_pkg::ST_IDLE:
          if (start_send)
            state_q <= csf_pkg::ST_SEND;
          else if (start_drop)
            state_q <= csf_pkg::ST_DROP;
        csf_pkg::ST_SEND:
          if (send_word && buf_eop[sel_q])
            state_q <= csf_pkg::ST_IDLE;
        csf_pkg::ST_DROP:
          if (drop_word && buf_eop[sel_q])
            state_q <= csf_pkg::ST_IDLE;
        default:
          state_q <= csf_pkg::ST_IDLE;
      endcase
    end
  end

  // Selected port and round-robin pointer
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_q <= 2'h0;
      rr_ptr_q <= 2'h0;
    end
    else if (start_send || start_drop)
    begin
      sel_q <= start_idx;
      // pointer moves past the port just served
      if (start_rr)
        rr_ptr_q <= rr_pick[1:0] + 2'h1;
    end
  end

  // buffer pops strictly in stored order, one word at a time
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      buf_pop_q <= 4'h0;
    else
      buf_pop_q <= (send_word || drop_word) ? (4'h1 << sel_q) : 4'h0;
  end

  // First-word marker of a forwarded packet
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      first_q <= 1'b0;
    else if (start_send)
      first_q <= 1'b1;
    else if (send_word)
      first_q <= 1'b0;
  end

  // hand a word to the link domain, hold it until acknowledged
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_q <= 1'b0;
      busy_q <= 1'b0;
      word_q <= '0;
      wfirst_q <= 1'b0;
      wlast_q <= 1'b0;
      wvc_q <= 2'h0;
    end
    else if (send_word)
    begin
      req_q <= ~req_q;
      busy_q <= 1'b1;
      word_q <= head_data[sel_q];
      wfirst_q <= first_q;
      wlast_q <= buf_eop[sel_q];
      wvc_q <= out_vc;
    end
    else if (ack_evt)
      busy_q <= 1'b0;
  end

  // Acknowledge toggle synchroniser
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_s_q <= 3'h0;
      ack_acc_q <= 1'b0;
    end
    else
    begin
      ack_s_q <= {ack_s_q[1:0], link.ack_tgl};
      if (ack_evt)
        ack_acc_q <= ack_s_q[2];
    end
  end

  // Source side of the handshake
  assign link.req_tgl = req_q;
  assign link.data = word_q;
  assign link.first = wfirst_q;
  assign link.last = wlast_q;
  assign link.vc = wvc_q;

  csf_tx_link #(.DATA_W(DATA_W)) u_tx (
    .tx_clk(tx_clk),
    .sys_rst(sys_rst),
    .link(link.dst),
    .tx_hs_q(tx_hs_q),
    .tx_valid_q(tx_valid_q),
    .tx_data_q(tx_data_q),
    .tx_first_q(tx_first_q),
    .tx_last_q(tx_last_q),
    .tx_vc_q(tx_vc_q)
  );
endmodule : csf_engine
`default_nettype wire

// file: inc/csf_pkg.sv
// Shared constants and types for the CSI-2 stream forwarding engine
package csf_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_PORT_MAP = 8'h20;
  localparam logic [7:0] ADDR_MODE = 8'h21;
  localparam logic [7:0] ADDR_STATUS = 8'h35;
  // Reset values
  localparam logic [7:0] PORT_MAP_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'hC0;
  // Field positions
  localparam int MAP_LSB = 4;
  localparam int DIS_LSB = 0;
  localparam int RR_BIT = 6;
  localparam int SYNC_LSB = 2;
  localparam int STS_SYNC_BIT = 1;
  localparam int STS_LOST_BIT = 2;
  // Synchronized variants
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_BASIC = 2'h1;
  localparam logic [1:0] SYNC_INTERLEAVE = 2'h2;
  localparam logic [1:0] SYNC_CONCAT = 2'h3;
  // Packet class at a buffer head
  typedef enum logic [1:0] {
    KIND_LINE = 2'h0,
    KIND_FS = 2'h1,
    KIND_FE = 2'h2,
    KIND_OTHER = 2'h3
  } csf_kind_type;
  // Forwarding states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SEND = 3'h2,
    ST_DROP = 3'h4
  } csf_state_type;
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int SYNC_WIN_NS = 30000;
  localparam int SYNC_WIN_CYC = SYNC_WIN_NS * CLK_MHZ / 1000;
endpackage : csf_pkg

// file: inc/csf_link_if.sv
// Word handshake between the forwarding logic and the link-side transmitter
`timescale 1ns/1ps
`default_nettype none
interface csf_link_if #(
  parameter int DATA_W = 32
);
  logic req_tgl;
  logic ack_tgl;
  logic [DATA_W-1:0] data;
  logic first;
  logic last;
  logic [1:0] vc;
  modport src (output req_tgl, output data, output first, output last, output vc, input ack_tgl);
  modport dst (input req_tgl, input data, input first, input last, input vc, output ack_tgl);
endinterface : csf_link_if
`default_nettype wire

// file: core/csf_tx_link.sv
// Link-side transmitter: takes handed-over words and drives the CSI-2 stream
`timescale 1ns/1ps
`default_nettype none
module csf_tx_link #(
  parameter int DATA_W = 32
) (
  // Link clock and reset
  input wire logic tx_clk,
  input wire logic sys_rst,
  // Words from the forwarding logic
  csf_link_if.dst link,
  // CSI-2 output
  output logic tx_hs_q,
  output logic tx_valid_q,
  output logic [DATA_W-1:0] tx_data_q,
  output logic tx_first_q,
  output logic tx_last_q,
  output logic [1:0] tx_vc_q
);
  logic [2:0] req_s_q;
  logic acc_q;
  logic evt;

  // New word once the two late stages agree on a changed toggle
  assign evt = (req_s_q[1] == req_s_q[2]) && (req_s_q[2] != acc_q);
  assign link.ack_tgl = acc_q;

  // Request synchroniser and acknowledge
  always_ff @(posedge tx_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_s_q <= 3'h0;
      acc_q <= 1'b0;
    end
    else
    begin
      req_s_q <= {req_s_q[1:0], link.req_tgl};
      if (evt)
        acc_q <= req_s_q[2];
    end
  end

  // Output word register; data is stable while the toggle is pending
  always_ff @(posedge tx_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q <= '0;
      tx_first_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_vc_q <= 2'h0;
    end
    else
    begin
      tx_valid_q <= evt;
      if (evt)
      begin
        tx_data_q <= link.data;
        tx_first_q <= link.first;
        tx_last_q <= link.last;
        tx_vc_q <= link.vc;
      end
    end
  end

  always_ff @(posedge tx_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_hs_q <= 1'b0;
    else if (evt)
      tx_hs_q <= 1'b1;
    else if (tx_valid_q && tx_last_q)
      tx_hs_q <= 1'b0;
  end
endmodule : csf_tx_link
`default_nettype wire

// file: verif/csf_engine_props.sv
// Port-level checker for the forwarding engine
`timescale 1ns/1ps
`default_nettype none
module csf_engine_props #(
  parameter logic TX_INDEX = 1'b0
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic tx_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  // Buffer side and status
  input wire logic [3:0] buf_pkt_ready,
  input wire logic [3:0] buf_pop_q,
  input wire logic sync_status_q,
  input wire logic sync_lost_q,
  // Link side
  input wire logic tx_hs_q,
  input wire logic tx_valid_q
);
  logic [7:0] map_q;
  logic [7:0] mode_q;
  // Ports that may not be popped, sync mode on, status read
  wire logic [3:0] blocked = map_q[3:0] | (map_q[7:4] ^ {4{TX_INDEX}});
  wire logic sync_on = !mode_q[csf_pkg::RR_BIT] && mode_q[3:2] != 2'h0;
  wire logic sts_rd = reg_rd && reg_addr == csf_pkg::ADDR_STATUS;
  // Shadow of the two control registers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      map_q <= csf_pkg::PORT_MAP_RST;
      mode_q <= csf_pkg::MODE_RST;
    end
    else if (reg_wr)
    begin
      map_q <= reg_addr == csf_pkg::ADDR_PORT_MAP ? reg_wdata : map_q;
      mode_q <= reg_addr == csf_pkg::ADDR_MODE ? reg_wdata : mode_q;
    end
  end
  a_pop_one_port: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $onehot0(buf_pop_q)) else $error("pop on two ports");
  a_pop_whole_pkt: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (buf_pop_q & ~$past(buf_pkt_ready)) == 4'h0) else $error("pop without packet");
  a_pop_not_blocked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (buf_pop_q & blocked) == 4'h0) else $error("pop of blocked port");
  a_pop_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    buf_pop_q != 4'h0 |=> buf_pop_q == 4'h0) else $error("pops back to back");
  a_sync_off_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !sync_on && !$past(sync_on) |-> !sync_status_q) else $error("synced while off");
  a_lost_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sync_lost_q && !sts_rd |=> sync_lost_q) else $error("lost flag dropped");
  a_status_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sts_rd |=> reg_rdata_q == {5'h00, $past(sync_lost_q), $past(sync_status_q), 1'b0})
    else $error("status read wrong");
  a_hs_with_word: assert property (@(posedge tx_clk) disable iff (sys_rst)
    tx_valid_q |-> tx_hs_q) else $error("word outside HS");
  // Main scenarios reached
  c_port3_pop: cover property (@(posedge ref_clk) disable iff (sys_rst) buf_pop_q[3]);
  c_synced: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(sync_status_q));
  c_lost: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(sync_lost_q));
endmodule : csf_engine_props
`default_nettype wire

// file: verif/csf_rx_model.sv
// Downstream receiver model: collects words sent in HS mode
`timescale 1ns/1ps
`default_nettype none
module csf_rx_model #(
  parameter int DATA_W = 32
) (
  // Link clock and reset
  input wire logic tx_clk,
  input wire logic sys_rst,
  // CSI-2 stream
  input wire logic tx_hs_q,
  input wire logic tx_valid_q,
  input wire logic [DATA_W-1:0] tx_data_q,
  input wire logic tx_first_q,
  input wire logic tx_last_q,
  input wire logic [1:0] tx_vc_q,
  // Received word {vc, first, last, data}
  output logic got_q,
  output logic [DATA_W+3:0] word_q
);
  always_ff @(posedge tx_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      got_q <= 1'b0;
      word_q <= '0;
    end
    else
    begin
      got_q <= tx_valid_q && tx_hs_q; // LP words are lost
      word_q <= tx_valid_q ? {tx_vc_q, tx_first_q, tx_last_q, tx_data_q} : word_q;
    end
  end
endmodule : csf_rx_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the forwarding engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int WIN = 40;
  localparam logic [7:0] A_MAP = csf_pkg::ADDR_PORT_MAP;
  localparam logic [7:0] A_MODE = csf_pkg::ADDR_MODE;
  localparam logic [7:0] A_STS = csf_pkg::ADDR_STATUS;
  int seed = 76699;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic ref_clk = 1'b0;
  logic tx_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] buf_pkt_ready = 4'h0;
  logic [127:0] buf_data = '0;
  logic [3:0] buf_eop = 4'h0;
  logic [7:0] buf_kind = 8'h00;
  logic [7:0] port_vc = 8'h00;
  logic [7:0] reg_rdata_q;
  logic [3:0] buf_pop_q;
  logic sync_status_q;
  logic sync_lost_q;
  logic tx_hs_q;
  logic tx_valid_q;
  logic [31:0] tx_data_q;
  logic tx_first_q;
  logic tx_last_q;
  logic [1:0] tx_vc_q;
  logic got;
  logic [35:0] word;
  // Buffer words {kind, eop, data}, pending and expected words {vc, first, last, data}
  logic [34:0] bq [4][$];
  logic [35:0] pq [4][$];
  logic [35:0] exq [$];
  logic [7:0] rq [$];
  csf_engine #(.SYNC_WIN_CYC(WIN)) uut (
    .ref_clk(ref_clk), .tx_clk(tx_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .buf_pkt_ready(buf_pkt_ready), .buf_data(buf_data), .buf_eop(buf_eop),
    .buf_kind(buf_kind), .port_vc(port_vc), .buf_pop_q(buf_pop_q),
    .sync_status_q(sync_status_q), .sync_lost_q(sync_lost_q),
    .tx_hs_q(tx_hs_q), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .tx_first_q(tx_first_q), .tx_last_q(tx_last_q), .tx_vc_q(tx_vc_q)
  );
  csf_rx_model u_rx (
    .tx_clk(tx_clk), .sys_rst(sys_rst), .tx_hs_q(tx_hs_q),
    .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .tx_first_q(tx_first_q),
    .tx_last_q(tx_last_q), .tx_vc_q(tx_vc_q), .got_q(got), .word_q(word)
  );
  // Clocks: 40 ns main, 160 ns link at a skewed phase
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    #7;
    forever #80 tx_clk = ~tx_clk;
  end
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    err_count += exq.size() + rq.size();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // Cycle ceiling cuts a hang short
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      $display("[FAIL] run expected done seen timeout");
      give_verdict();
    end
  end
  // Buffers pop on the pulse and show their head word, noise when empty
  always @(negedge ref_clk)
  begin
    for (int p = 0; p < 4; p++)
    begin
      if (buf_pop_q[p] === 1'b1 && bq[p].size() > 0)
        void'(bq[p].pop_front());
      buf_pkt_ready[p] = bq[p].size() > 0;
      {buf_kind[2*p +: 2], buf_eop[p], buf_data[32*p +: 32]} = buf_pkt_ready[p] ? bq[p][0] : 35'($random(seed));
    end
  end
  // Read data one cycle after the strobe; words from the receiver
  always @(posedge ref_clk)
    rd_seen <= reg_rd;
  always @(negedge ref_clk)
    if (rd_seen)
      chk("reg_rdata_q", {28'h0, reg_rdata_q}, {28'h0, rq.pop_front()});
  always @(negedge tx_clk)
    if (got === 1'b1)
      chk("tx word", word, exq.size() > 0 ? exq.pop_front() : ~word);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    rq.push_back(e);
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask : rd
  // A whole packet of random words into one buffer
  task automatic push(input int p, input logic [1:0] k, input int n);
    logic [31:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = $random(seed);
      bq[p].push_back({k, i == n - 1, d});
      pq[p].push_back({port_vc[2*p +: 2], i == 0, i == n - 1, d});
    end
  endtask : push
  // Oldest pending packet of a port is expected, or dropped
  task automatic take(input int p, input bit keep);
    logic [35:0] w;
    do
    begin
      w = pq[p].pop_front();
      if (keep)
        exq.push_back(w);
    end
    while (!w[32]);
  endtask : take
  task automatic frame(input int p);
    push(p, csf_pkg::KIND_FS, 1);
    push(p, csf_pkg::KIND_LINE, 2);
    push(p, csf_pkg::KIND_LINE, 3);
    push(p, csf_pkg::KIND_FE, 1);
  endtask : frame
  task automatic drain();
    for (int n = 0; n < 4000 && exq.size() > 0; n++)
      @(negedge ref_clk);
    repeat (40) @(negedge ref_clk);
  endtask : drain
  initial
  begin
    port_vc = 8'($random(seed));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    // reset values, unmapped place reads zero
    rd(A_MAP, csf_pkg::PORT_MAP_RST);
    rd(A_MODE, csf_pkg::MODE_RST);
    rd(A_STS, 8'h00);
    wr(8'h7E, 8'hA5);
    rd(8'h7E, 8'h00);
    wr(A_MAP, 8'h84);
    rd(A_MAP, 8'h84);
    $display("test registers done");
    // round-robin, port 2 disabled, port 3 mapped away
    push(0, csf_pkg::KIND_LINE, 3);
    push(0, csf_pkg::KIND_OTHER, 2);
    push(1, csf_pkg::KIND_FS, 1);
    push(2, csf_pkg::KIND_LINE, 2);
    push(3, csf_pkg::KIND_FE, 3);
    take(0, 1);
    take(1, 1);
    take(0, 1);
    drain();
    chk("held", 36'(bq[2].size() * 8 + bq[3].size()), 36'h13);
    wr(A_MAP, 8'h00);
    take(2, 1);
    take(3, 1);
    drain();
    $display("test round_robin done");
    // round-robin off, ports on, then basic sync
    wr(A_MODE, 8'h00);
    wr(A_MAP, 8'h00);
    wr(A_MODE, {4'h0, csf_pkg::SYNC_BASIC, 2'h0});
    // port 3 leads the others by a few cycles
    frame(3);
    repeat (5) @(negedge ref_clk);
    for (int p = 0; p < 3; p++)
      frame(p);
    // each packet kind in port order
    for (int k = 0; k < 4; k++)
      for (int p = 0; p < 4; p++)
        take(p, 1);
    drain();
    rd(A_STS, 8'h02);
    chk("sync_status_q", 36'(sync_status_q), 36'h1);
    $display("test sync_basic done");
    // port 0 silent, the others are discarded
    for (int p = 1; p < 4; p++)
    begin
      push(p, csf_pkg::KIND_LINE, 2);
      take(p, 0);
    end
    repeat (WIN + 100) @(negedge ref_clk);
    chk("flushed", 36'(bq[1].size() + bq[2].size() + bq[3].size()), 36'h0);
    chk("sync_lost_q", 36'(sync_lost_q), 36'h1);
    rd(A_STS, 8'h04);
    rd(A_STS, 8'h00);
    for (int p = 0; p < 4; p++)
      frame(p);
    for (int k = 0; k < 4; k++)
      for (int p = 0; p < 4; p++)
        take(p, 1);
    drain();
    rd(A_STS, 8'h02);
    $display("test sync_loss done");
    // every sync variant accepted, then round-robin again
    for (int v = 1; v < 4; v++)
    begin
      wr(A_MODE, {4'h0, 2'(v), 2'h0});
      rd(A_MODE, {4'h0, 2'(v), 2'h0});
    end
    // line-interleave keeps port 0's FS, FE and VC only
    wr(A_MODE, {4'h0, csf_pkg::SYNC_INTERLEAVE, 2'h0});
    for (int p = 0; p < 4; p++)
      frame(p);
    for (int p = 1; p < 4; p++)
      for (int i = 0; i < pq[p].size(); i++)
        pq[p][i][35:34] = port_vc[1:0];
    for (int k = 0; k < 4; k++)
      for (int p = 0; p < 4; p++)
        take(p, p == 0 || k == 1 || k == 2);
    drain();
    rd(A_STS, 8'h02);
    wr(A_MODE, csf_pkg::MODE_RST);
    repeat (3) @(negedge ref_clk);
    rd(A_STS, 8'h00);
    chk("sync_status_q", 36'(sync_status_q), 36'h0);
    push(2, csf_pkg::KIND_LINE, 2);
    take(2, 1);
    drain();
    $display("test modes done");
    give_verdict();
  end
endmodule : tb
bind csf_engine csf_engine_props #(.TX_INDEX(TX_INDEX)) u_props (
  .ref_clk(ref_clk), .tx_clk(tx_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .buf_pkt_ready(buf_pkt_ready), .buf_pop_q(buf_pop_q), .sync_status_q(sync_status_q),
  .sync_lost_q(sync_lost_q), .tx_hs_q(tx_hs_q), .tx_valid_q(tx_valid_q)
);
`default_nettype wire
